// file: core/timer_channel_capture_compare_pwm.sv
// Purpose: six capture/compare/PWM channels of a 16-bit timer behind an APB register file
// Assumes: counter value and overflow pulse come from the shared counter on sys_clk_i
// Notes: pins are sampled as synchronous inputs; odd channels pair with the even one below
//
// Overview of operation
// - capture mode sets the event flag on the selected pin edge.
// - compare mode sets the event flag when counter equals channel value.
// - flag clears by reading status with flag set, then writing zero.
// - with irq enable high, an event between that read and the clearing write keeps the flag.
// - writing one to the flag does nothing; reset clears all control bits.
// - interrupt enable bit permits or blocks the channel interrupt request.
// - only even channels have buffered mode; it disables the odd partner.
// - with edge/level nonzero, mode bit low picks capture or compare.
// - with edge/level zero, mode bit low presets output level; pin released.
// - with edge/level zero the pin is released but channel keeps state.
// - capture edge codes: 01 rising, 10 falling, 11 either edge.
// - compare codes: 01 toggle, 10 clear, 11 set, also when buffered.
// - buffered mode alternates the paired channel values as compare value.
// - overflow toggle flips the output on overflow; none in capture mode.
// - overflow action wins over a compare match in the same cycle.
// - with overflow toggle set, full-duty bit forces 100% duty from the next PWM period.
// - channel value holds capture or compare value; reset loads 0000h.
// - reading high byte in capture mode blocks captures until low read.
// - writing high byte in compare mode blocks matches until low written.
module timer_channel_capture_compare_pwm (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [timer_channel_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // shared counter
    input wire logic [15:0] counter_value_i,
    input wire logic counter_overflow_i,
    // channel pins
    input wire logic [timer_channel_pkg::NUM_CH-1:0] channel_pin_i,
    output logic [timer_channel_pkg::NUM_CH-1:0] channel_pin_o,
    output logic [timer_channel_pkg::NUM_CH-1:0] channel_pin_oe_b_o,
    // interrupt requests
    output logic [timer_channel_pkg::NUM_CH-1:0] channel_irq_o
);

    typedef struct packed {
        logic channel_event_flag;
        logic channel_irq_enable;
        logic buffered_mode_select;
        logic mode_select_low;
        logic [1:0] edge_level;
        logic overflow_toggle_enable;
        logic full_duty_force;
        logic full_duty_active;
        logic [15:0] value;
        logic capture_hold;
        logic compare_hold;
        logic clear_armed;
        logic out_level;
        logic pin_prev;
        logic use_partner;
        logic next_partner;
    } chan_t;

    typedef struct packed {
        chan_t [timer_channel_pkg::NUM_CH-1:0] ch;
    } timer_state_t;

    timer_state_t st_reg;
    timer_state_t st_next;

    // bus strobes
    logic [timer_channel_pkg::NUM_CH-1:0] wr_sc;
    logic [timer_channel_pkg::NUM_CH-1:0] wr_hi;
    logic [timer_channel_pkg::NUM_CH-1:0] wr_lo;
    logic [timer_channel_pkg::NUM_CH-1:0] rd_sc;
    logic [timer_channel_pkg::NUM_CH-1:0] rd_hi;
    logic [timer_channel_pkg::NUM_CH-1:0] rd_lo;
    logic [7:0] wdata;
    logic rd_flag_seen;
    logic [timer_channel_pkg::NUM_CH*24-1:0] rd_bytes;

    // per-channel derived terms
    logic [timer_channel_pkg::NUM_CH-1:0] disabled;
    logic [15:0] partner_value [timer_channel_pkg::NUM_CH];
    timer_channel_pkg::chan_mode_t mode [timer_channel_pkg::NUM_CH];

    channel_apb_slave u_apb (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .rd_bytes_i(rd_bytes),
        .wr_sc_o(wr_sc),
        .wr_hi_o(wr_hi),
        .wr_lo_o(wr_lo),
        .rd_sc_o(rd_sc),
        .rd_hi_o(rd_hi),
        .rd_lo_o(rd_lo),
        .wdata_o(wdata),
        .rd_flag_seen_o(rd_flag_seen)
    );

    genvar g;
    generate
        for (g = 0; g < timer_channel_pkg::NUM_CH; g++) begin : g_chan
            chan_t c;
            logic [7:0] sc_byte;
            logic compare_mode;
            assign c = st_reg.ch[g];
            if (g % 2 == 1) begin : g_odd
                // odd channel goes dark while its even partner is buffered
                assign disabled[g] = st_reg.ch[g-1].buffered_mode_select;
                assign partner_value[g] = c.value;
            end else begin : g_even
                assign disabled[g] = 1'b0;
                assign partner_value[g] = st_reg.ch[g+1].value;
            end
            assign mode[g] = timer_channel_pkg::chan_mode(c.buffered_mode_select, c.mode_select_low,
                                                          c.edge_level, disabled[g]);
            assign sc_byte = disabled[g] ? 8'h00 : {c.channel_event_flag, c.channel_irq_enable,
                                                    c.buffered_mode_select, c.mode_select_low,
                                                    c.edge_level, c.overflow_toggle_enable,
                                                    c.full_duty_force};
            assign rd_bytes[g*24 +: 24] = {sc_byte, c.value};
            assign compare_mode = (mode[g] == timer_channel_pkg::MODE_COMPARE) ||
                                  (mode[g] == timer_channel_pkg::MODE_BUFFERED);
            // pin released in idle and capture; driven only by compare/pwm
            assign channel_pin_oe_b_o[g] = !compare_mode;
            assign channel_pin_o[g] = c.out_level;
            assign channel_irq_o[g] = c.channel_event_flag && c.channel_irq_enable;
        end
    endgenerate

    always_comb begin
        chan_t c;
        chan_t n;
        logic rise;
        logic fall;
        logic capture_event;
        logic compare_event;
        logic any_event;
        logic overflow_action;
        logic is_compare;
        logic [15:0] compare_value;
        c = '0;
        n = '0;
        rise = 1'b0;
        fall = 1'b0;
        capture_event = 1'b0;
        compare_event = 1'b0;
        any_event = 1'b0;
        overflow_action = 1'b0;
        is_compare = 1'b0;
        compare_value = 16'h0000;
        st_next = st_reg;
        for (int i = 0; i < timer_channel_pkg::NUM_CH; i++) begin
            c = st_reg.ch[i];
            n = st_next.ch[i];
            is_compare = (mode[i] == timer_channel_pkg::MODE_COMPARE) ||
                         (mode[i] == timer_channel_pkg::MODE_BUFFERED);
            // edge detect on the channel pin
            rise = channel_pin_i[i] && !c.pin_prev;
            fall = !channel_pin_i[i] && c.pin_prev;
            n.pin_prev = channel_pin_i[i];
            capture_event = (mode[i] == timer_channel_pkg::MODE_CAPTURE) && !c.capture_hold &&
                            ((c.edge_level[0] && rise) || (c.edge_level[1] && fall));
            // buffered pair alternates the active compare value
            compare_value = (mode[i] == timer_channel_pkg::MODE_BUFFERED && c.use_partner) ?
                            partner_value[i] : c.value;
            compare_event = is_compare && !c.compare_hold &&
                            (counter_value_i == compare_value);
            any_event = capture_event || compare_event;
            if (capture_event) begin
                n.value = counter_value_i;
            end
            // output level
            overflow_action = is_compare && counter_overflow_i && c.overflow_toggle_enable;
            if (mode[i] == timer_channel_pkg::MODE_IDLE) begin
                n.out_level = !c.mode_select_low;
            end else if (overflow_action) begin
                // overflow wins over a same-cycle match; full duty latched per period
                n.full_duty_active = c.full_duty_force;
                n.out_level = c.full_duty_force ? 1'b1 : !c.out_level;
            end else if (compare_event && !c.full_duty_active) begin
                unique case (c.edge_level)
                    timer_channel_pkg::EDGE_LEVEL_TOGGLE: n.out_level = !c.out_level;
                    timer_channel_pkg::EDGE_LEVEL_CLEAR: n.out_level = 1'b0;
                    timer_channel_pkg::EDGE_LEVEL_SET: n.out_level = 1'b1;
                    default: n.out_level = c.out_level;
                endcase
            end
            if (!c.overflow_toggle_enable) begin
                n.full_duty_active = 1'b0;
            end
            if (counter_overflow_i && mode[i] == timer_channel_pkg::MODE_BUFFERED) begin
                n.use_partner = c.next_partner;
            end
            // status/control write
            if (wr_sc[i] && !disabled[i]) begin
                n.channel_irq_enable = wdata[timer_channel_pkg::BIT_IRQ_ENABLE];
                n.buffered_mode_select = (i % 2 == 0) && wdata[timer_channel_pkg::BIT_BUFFERED_MODE];
                n.mode_select_low = wdata[timer_channel_pkg::BIT_MODE_LOW];
                n.edge_level = {wdata[timer_channel_pkg::BIT_EDGE_LEVEL_HIGH],
                                wdata[timer_channel_pkg::BIT_EDGE_LEVEL_LOW]};
                n.overflow_toggle_enable = wdata[timer_channel_pkg::BIT_OVERFLOW_TOGGLE];
                n.full_duty_force = wdata[timer_channel_pkg::BIT_FULL_DUTY];
                // writing one leaves the flag alone; zero clears after the read, or at once while the irq enable is low
                if (!wdata[timer_channel_pkg::BIT_EVENT_FLAG] && (c.clear_armed || !c.channel_irq_enable)) begin
                    n.channel_event_flag = 1'b0;
                end
                n.clear_armed = 1'b0;
            end
            if (rd_sc[i] && !disabled[i] && rd_flag_seen) begin
                n.clear_armed = 1'b1;
            end
            // value byte accesses and their interlocks
            if (rd_hi[i] && mode[i] == timer_channel_pkg::MODE_CAPTURE) begin
                n.capture_hold = 1'b1;
            end
            if (rd_lo[i]) begin
                n.capture_hold = 1'b0;
            end
            if (wr_hi[i]) begin
                n.value[15:8] = wdata;
                n.compare_hold = is_compare || (i % 2 == 1 && disabled[i]);
            end
            if (wr_lo[i]) begin
                n.value[7:0] = wdata;
                n.compare_hold = 1'b0;
                if (i % 2 == 0) begin
                    n.next_partner = 1'b0;
                end
            end
            // a new event sets the flag and cancels a pending clear
            if (any_event) begin
                n.channel_event_flag = 1'b1;
                n.clear_armed = 1'b0;
            end
            st_next.ch[i] = n;
            // odd low byte written: partner value becomes next active in the pair
            if (i % 2 == 1 && wr_lo[i]) begin
                st_next.ch[i-1].next_partner = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // reset clears flag, enable, mode, edge/level and toggle bits
            for (int i = 0; i < timer_channel_pkg::NUM_CH; i++) begin
                st_reg.ch[i] <= '{channel_event_flag: timer_channel_pkg::STATUS_CONTROL_RST[7],
                                  channel_irq_enable: timer_channel_pkg::STATUS_CONTROL_RST[6],
                                  buffered_mode_select: timer_channel_pkg::STATUS_CONTROL_RST[5],
                                  mode_select_low: timer_channel_pkg::STATUS_CONTROL_RST[4],
                                  edge_level: timer_channel_pkg::STATUS_CONTROL_RST[3:2],
                                  overflow_toggle_enable: timer_channel_pkg::STATUS_CONTROL_RST[1],
                                  full_duty_force: timer_channel_pkg::STATUS_CONTROL_RST[0],
                                  full_duty_active: 1'b0,
                                  value: timer_channel_pkg::CHANNEL_VALUE_RST,
                                  capture_hold: 1'b0,
                                  compare_hold: 1'b0,
                                  clear_armed: 1'b0,
                                  out_level: 1'b1,
                                  pin_prev: 1'b0,
                                  use_partner: 1'b0,
                                  next_partner: 1'b0};
            end
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// file: common/timer_channel_pkg.sv
// Purpose: shared constants, types and decoding for the six-channel capture/compare timer block
// Assumes: one 32-bit aligned APB word per 8-bit register, data in bits 7:0
// Notes: channel register groups sit at a fixed stride in the APB space
package timer_channel_pkg;

    localparam int NUM_CH = 6;
    localparam int ADDR_W = 8;

    // register map: channel n group starts at n * CH_STRIDE
    localparam logic [3:0] CH_FIELD_MAX = 4'h5;
    localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_VALUE_HIGH = 4'h4;
    localparam logic [3:0] OFS_VALUE_LOW = 4'h8;
    localparam logic [7:0] CH_STRIDE = 8'h10;

    // channel_status_control field positions
    localparam int BIT_EVENT_FLAG = 7;
    localparam int BIT_IRQ_ENABLE = 6;
    localparam int BIT_BUFFERED_MODE = 5;
    localparam int BIT_MODE_LOW = 4;
    localparam int BIT_EDGE_LEVEL_HIGH = 3;
    localparam int BIT_EDGE_LEVEL_LOW = 2;
    localparam int BIT_OVERFLOW_TOGGLE = 1;
    localparam int BIT_FULL_DUTY = 0;

    // values after reset
    localparam logic [7:0] STATUS_CONTROL_RST = 8'h00;
    localparam logic [15:0] CHANNEL_VALUE_RST = 16'h0000;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

    // edge/level codes
    localparam logic [1:0] EDGE_LEVEL_OFF = 2'h0;
    localparam logic [1:0] EDGE_LEVEL_TOGGLE = 2'h1;
    localparam logic [1:0] EDGE_LEVEL_CLEAR = 2'h2;
    localparam logic [1:0] EDGE_LEVEL_SET = 2'h3;

    // register kinds seen by the bus slave
    typedef enum logic [1:0] {
        KIND_STATUS_CONTROL = 2'h0,
        KIND_VALUE_HIGH = 2'h1,
        KIND_VALUE_LOW = 2'h3
    } reg_kind_t;

    // channel function, gray coded
    typedef enum logic [1:0] {
        MODE_IDLE = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_COMPARE = 2'h3,
        MODE_BUFFERED = 2'h2
    } chan_mode_t;

    function automatic chan_mode_t chan_mode(input logic buffered, input logic mode_low,
                                             input logic [1:0] edge_level, input logic disabled);
        chan_mode_t m;
        m = MODE_IDLE;
        if (disabled || edge_level == EDGE_LEVEL_OFF) begin
            m = MODE_IDLE;
        end else if (buffered) begin
            m = MODE_BUFFERED;
        end else if (mode_low) begin
            m = MODE_COMPARE;
        end else begin
            m = MODE_CAPTURE;
        end
        return m;
    endfunction

endpackage

// file: core/channel_apb_slave.sv
// Purpose: APB slave front end, decodes byte registers into per-channel strobes
// Assumes: zero wait states; read data registered during the setup phase
// Notes: unmapped addresses answer with pslverr and zero data
module channel_apb_slave (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [timer_channel_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // register contents, 3 bytes per channel: status, high, low
    input wire logic [timer_channel_pkg::NUM_CH*24-1:0] rd_bytes_i,
    // strobes toward channel logic
    output logic [timer_channel_pkg::NUM_CH-1:0] wr_sc_o,
    output logic [timer_channel_pkg::NUM_CH-1:0] wr_hi_o,
    output logic [timer_channel_pkg::NUM_CH-1:0] wr_lo_o,
    output logic [timer_channel_pkg::NUM_CH-1:0] rd_sc_o,
    output logic [timer_channel_pkg::NUM_CH-1:0] rd_hi_o,
    output logic [timer_channel_pkg::NUM_CH-1:0] rd_lo_o,
    output logic [7:0] wdata_o,
    output logic rd_flag_seen_o
);

    typedef struct packed {
        logic [31:0] prdata;
        logic err;
    } slave_state_t;

    slave_state_t st_reg;
    slave_state_t st_next;

    // returns {valid, channel[2:0], kind[1:0]}
    function automatic logic [5:0] decode(input logic [timer_channel_pkg::ADDR_W-1:0] addr);
        logic ok;
        logic [1:0] kind;
        ok = (addr[7:4] <= timer_channel_pkg::CH_FIELD_MAX);
        kind = timer_channel_pkg::KIND_STATUS_CONTROL;
        unique case (addr[3:0])
            timer_channel_pkg::OFS_STATUS_CONTROL: kind = timer_channel_pkg::KIND_STATUS_CONTROL;
            timer_channel_pkg::OFS_VALUE_HIGH: kind = timer_channel_pkg::KIND_VALUE_HIGH;
            timer_channel_pkg::OFS_VALUE_LOW: kind = timer_channel_pkg::KIND_VALUE_LOW;
            default: ok = 1'b0;
        endcase
        return {ok, addr[6:4], kind};
    endfunction

    logic [5:0] dec;
    logic access;
    logic [7:0] sel_byte;

    always_comb begin
        dec = decode(paddr_i);
        sel_byte = 8'h00;
        unique case (dec[1:0])
            timer_channel_pkg::KIND_VALUE_HIGH: sel_byte = rd_bytes_i[dec[4:2]*24+8 +: 8];
            timer_channel_pkg::KIND_VALUE_LOW: sel_byte = rd_bytes_i[dec[4:2]*24 +: 8];
            default: sel_byte = rd_bytes_i[dec[4:2]*24+16 +: 8];
        endcase
        st_next = st_reg;
        if (psel_i && !penable_i) begin
            st_next.err = !dec[5];
            st_next.prdata = (dec[5] && !pwrite_i) ? {24'h00_0000, sel_byte} : timer_channel_pkg::PRDATA_RST;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '{prdata: timer_channel_pkg::PRDATA_RST, err: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign access = psel_i && penable_i && dec[5];
    assign prdata_o = st_reg.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && st_reg.err;
    assign wdata_o = pwdata_i[7:0];
    assign rd_flag_seen_o = st_reg.prdata[timer_channel_pkg::BIT_EVENT_FLAG];

    genvar g;
    generate
        for (g = 0; g < timer_channel_pkg::NUM_CH; g++) begin : g_strobe
            logic hit;
            assign hit = access && (dec[4:2] == 3'(g));
            assign wr_sc_o[g] = hit && pwrite_i && dec[1:0] == timer_channel_pkg::KIND_STATUS_CONTROL;
            assign wr_hi_o[g] = hit && pwrite_i && dec[1:0] == timer_channel_pkg::KIND_VALUE_HIGH;
            assign wr_lo_o[g] = hit && pwrite_i && dec[1:0] == timer_channel_pkg::KIND_VALUE_LOW;
            assign rd_sc_o[g] = hit && !pwrite_i && dec[1:0] == timer_channel_pkg::KIND_STATUS_CONTROL;
            assign rd_hi_o[g] = hit && !pwrite_i && dec[1:0] == timer_channel_pkg::KIND_VALUE_HIGH;
            assign rd_lo_o[g] = hit && !pwrite_i && dec[1:0] == timer_channel_pkg::KIND_VALUE_LOW;
        end
    endgenerate

endmodule

// file: dv/timer_channel_capture_compare_pwm_properties.sv
// Purpose: port-level assertions for the capture/compare channel block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every instance of the block
module timer_channel_capture_compare_pwm_properties (
    // clock, reset, apb
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [timer_channel_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // counter and channels
    input wire logic [15:0] counter_value_i,
    input wire logic counter_overflow_i,
    input wire logic [timer_channel_pkg::NUM_CH-1:0] channel_pin_i,
    input wire logic [timer_channel_pkg::NUM_CH-1:0] channel_pin_o,
    input wire logic [timer_channel_pkg::NUM_CH-1:0] channel_pin_oe_b_o,
    input wire logic [timer_channel_pkg::NUM_CH-1:0] channel_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_acc;
    assign wr_acc = psel_i && penable_i && pwrite_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_reset_quiet: assert property ($rose(rst_b_i) |-> channel_irq_o == '0 && &channel_pin_oe_b_o)
        else $error("outputs not idle after reset");
    chk_irq_drop_write: assert property ((($past(channel_irq_o) & ~channel_irq_o) != '0) |-> $past(wr_acc))
        else $error("irq dropped without a register write");
    chk_irq_rise_cause: assert property (((channel_irq_o & ~$past(channel_irq_o)) != '0) |->
        $past(wr_acc) || $past(wr_acc, 2) || $past(channel_pin_i) != $past(channel_pin_i, 2)
        || $past(counter_value_i) != $past(counter_value_i, 2)) else $error("irq rose without a cause");
    chk_oe_by_write: assert property ($changed(channel_pin_oe_b_o) |-> $past(wr_acc))
        else $error("pin enable changed without a write");
    chk_idle_pin_hold: assert property ((((channel_pin_o ^ $past(channel_pin_o)) & channel_pin_oe_b_o
        & $past(channel_pin_oe_b_o)) != '0) |-> $past(wr_acc, 2)) else $error("released channel level moved");
    chk_prdata_hold: assert property (!$past(psel_i && !penable_i) |-> $stable(prdata_o))
        else $error("read data changed outside setup");
    chk_err_access: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("error outside access phase");
    chk_rdata_upper: assert property (prdata_o[31:8] == '0)
        else $error("read data upper bits not zero");
endmodule
bind timer_channel_capture_compare_pwm timer_channel_capture_compare_pwm_properties chk_i (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .counter_value_i(counter_value_i), .counter_overflow_i(counter_overflow_i), .channel_pin_i(channel_pin_i),
    .channel_pin_o(channel_pin_o), .channel_pin_oe_b_o(channel_pin_oe_b_o), .channel_irq_o(channel_irq_o));

// file: dv/channel_pin_model.sv
// Purpose: outside world of the six channel pins
// Assumes: released pins follow the requested level
// Notes: driven pins read back the channel's own level
module channel_pin_model (
    // levels and channel drive
    input wire logic [timer_channel_pkg::NUM_CH-1:0] level_req_i,
    input wire logic [timer_channel_pkg::NUM_CH-1:0] drive_i,
    input wire logic [timer_channel_pkg::NUM_CH-1:0] drive_oe_b_i,
    // resolved pin
    output logic [timer_channel_pkg::NUM_CH-1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels only change when the bench asks, so they stay stable before capture is enabled
    assign pin_o = (drive_i & ~drive_oe_b_i) | (level_req_i & drive_oe_b_i);
endmodule

// file: dv/tb_timer_channel_capture_compare_pwm.sv
// Purpose: register-level tests of the capture/compare channel block
// Assumes: zero-wait apb, counter and overflow driven by the bench
// Notes: counter idles at 8000h, away from every programmed value
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_timer_channel_capture_compare_pwm;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [15:0] cnt = 16'h8000;
    logic ovf = 1'b0;
    logic [5:0] pin_req = 6'h00;
    logic [31:0] prdata;
    logic pready, pslverr, err;
    logic [5:0] pin_in, pin_out, oe_b, irq;
    logic [7:0] q;
    int n_mismatch = 0;
    int num_checks = 0;
    timer_channel_capture_compare_pwm timer_channel_capture_compare_pwm_i (.sys_clk_i(clk), .rst_b_i(rst_b),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .counter_value_i(cnt),
        .counter_overflow_i(ovf), .channel_pin_i(pin_in), .channel_pin_o(pin_out),
        .channel_pin_oe_b_o(oe_b), .channel_irq_o(irq));
    channel_pin_model channel_pin_model_i (.level_req_i(pin_req), .drive_i(pin_out), .drive_oe_b_i(oe_b),
        .pin_o(pin_in));
    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        `CHK($sformatf("read %h", a), e, q)
    endtask
    task automatic ev(input logic [15:0] c, input logic o, input logic [5:0] p);
        @(posedge clk);
        cnt <= c;
        ovf <= o;
        pin_req <= p;
        @(posedge clk);
        cnt <= 16'h8000; // parked while modes change
        ovf <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        #50000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        `CHK("irq", 6'h00, irq)
        `CHK("oe", 6'h3f, oe_b)
        rdchk(8'h50, 8'h00);
        xfer(1'b1, 8'h50, 8'h80);
        rdchk(8'h50, 8'h00);
        for (int c = 1; c < 4; c++) begin
            xfer(1'b1, 8'h10, 8'h40 | 8'(c << 2));
            ev(16'h1100 | 16'(c), 1'b0, 6'h02);
            `CHK("rise", 1'(c != 2), irq[1])
            ev(16'h2200 | 16'(c), 1'b0, 6'h00);
            `CHK("flag", 1'b1, irq[1])
            xfer(1'b1, 8'h10, 8'h40 | 8'(c << 2));
            `CHK("unarmed", 1'b1, irq[1])
            rdchk(8'h14, (c == 1) ? 8'h11 : 8'h22);
            rdchk(8'h18, 8'(c));
            rdchk(8'h10, 8'hc0 | 8'(c << 2));
            if (c == 3) ev(16'h3300, 1'b0, 6'h02);
            xfer(1'b1, 8'h10, 8'h40 | 8'(c << 2));
            `CHK("race", 1'(c == 3), irq[1])
            xfer(1'b0, 8'h10, 8'h00);
            xfer(1'b1, 8'h10, 8'h40 | 8'(c << 2));
            `CHK("clear", 1'b0, irq[1])
        end
        xfer(1'b1, 8'h04, 8'h00);
        xfer(1'b1, 8'h08, 8'h50);
        for (int t = 1; t < 4; t++) begin
            xfer(1'b1, 8'h00, 8'h10);
            `CHK("released", 1'b1, oe_b[0])
            xfer(1'b1, 8'h00, 8'h50 | 8'(t << 2));
            `CHK("driven", 1'b0, oe_b[0])
            `CHK("preset", 1'b0, pin_out[0])
            ev(16'h0050, 1'b0, 6'h02);
            `CHK("cmp1", 1'(t != 2), pin_out[0])
            `CHK("cmpflag", 1'b1, irq[0])
            ev(16'h0050, 1'b0, 6'h02);
            `CHK("cmp2", 1'(t == 3), pin_out[0])
        end
        xfer(1'b1, 8'h00, 8'h10);
        xfer(1'b1, 8'h00, 8'h5a);
        ev(16'h0050, 1'b1, 6'h02);
        `CHK("ovf wins", 1'b1, pin_out[0])
        ev(16'h8000, 1'b1, 6'h02);
        `CHK("ovf tog", 1'b0, pin_out[0])
        xfer(1'b1, 8'h00, 8'h5b);
        ev(16'h8000, 1'b1, 6'h02);
        ev(16'h0050, 1'b0, 6'h02);
        `CHK("full", 1'b1, pin_out[0])
        xfer(1'b1, 8'h00, 8'h74);
        rdchk(8'h10, 8'h00);
        xfer(1'b1, 8'h10, 8'h54);
        rdchk(8'h10, 8'h00);
        `CHK("odd oe", 1'b1, oe_b[1])
        `CHK("buf oe", 1'b0, oe_b[0])
        xfer(1'b1, 8'h24, 8'h00);
        xfer(1'b1, 8'h28, 8'h30);
        xfer(1'b1, 8'h20, 8'h54);
        xfer(1'b1, 8'h24, 8'h00);
        ev(16'h0030, 1'b0, 6'h02);
        `CHK("held", 1'b0, irq[2])
        xfer(1'b1, 8'h28, 8'h30);
        ev(16'h0030, 1'b0, 6'h02);
        `CHK("match", 1'b1, irq[2])
        rdchk(8'h28, 8'h30);
        xfer(1'b0, 8'h60, 8'h00);
        `CHK("unmapped", 1'b1, err)
        end_of_test();
    end
endmodule
